// [scg_pkg.sv]
// Purpose: constants for the system clock gear and protect block
// Assumes: 32-bit apb, one register per aligned word
// Notes: printed offsets are word indexes; byte address is four times
package scg_pkg;
   // =========================================
   // register indexes (byte address = 4 * index)
   localparam logic [13:0] IDX_OSC = 14'h10e0;
   localparam logic [13:0] IDX_SRC = 14'h10e1;
   localparam logic [13:0] IDX_WCF = 14'h10e2;
   localparam logic [13:0] IDX_STA = 14'h10e3;
   localparam logic [13:0] IDX_KA = 14'h10e4;
   localparam logic [13:0] IDX_KB = 14'h10e5;
   // =========================================
   // field positions
   localparam int B_HEN = 7;
   localparam int B_LEN = 6;
   localparam int B_WUP = 2;
   localparam int B_SRC = 3;
   localparam int B_WSEL = 4;
   localparam int B_PIN = 0;
   localparam int B_PROT = 7;
   localparam int B_EXT = 2;
   localparam int B_HDRV = 1;
   localparam int B_LDRV = 0;
   // =========================================
   // reset values and codes
   localparam logic [2:0] RST_GEAR = 3'h4;
   localparam logic [1:0] RST_WSEL = 2'h2;
   localparam logic [7:0] KEY_P = 8'h5a;
   localparam logic [7:0] KEY_Q = 8'ha5;
   localparam int WARM_EXP_S = 8;
   localparam int WARM_EXP_M = 14;
   localparam int WARM_EXP_L = 16;
   typedef enum logic [1:0] {KS_IDLE, KS_1A, KS_1B, KS_2A} scg_key_t;
endpackage

// [scg_clock_ctrl.sv]
// Purpose: system clock select, gear, warm-up timer, write protection
// Assumes: oscillator clocks are sampled as synchronous inputs of mclk_i
// Notes: clocks leave as one-cycle enables of mclk_i
// How it works
// - system clock from high or low oscillator
// - gear divides high clock by 1..16
// - reset: both on, high source, gear 100
// - warm-up counts 2^8, 2^14 or 2^16
// - warm-up counts target oscillator edges only
// - writing start bit clears and starts warm-up
// - each oscillator runs per its enable bit, the high one only with external clock off
// - high drive bit zero weakens drive
// - low drive bit zero weakens drive
// - external clock: oscillator off, out pin high
// - protection blocks writes to clock registers
// - two ordered key pairs toggle protection
// - protection state readable in status register
// - protection off after reset
// - protected write raises violation request
// - start bit zero ignored, reads busy
// - pin-state bit picks standby pin behaviour
module scg_clock_ctrl
   import scg_pkg::*;
#(
   parameter int WARM_S = 1 << WARM_EXP_S,
   parameter int WARM_M = 1 << WARM_EXP_M,
   parameter int WARM_L = 1 << WARM_EXP_L
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic high_freq_clock_i,
   input wire logic low_freq_clock_i,
   input wire logic ext_protected_write_i,
   output logic high_osc_run_o,
   output logic low_osc_run_o,
   output logic high_osc_drive_o,
   output logic low_osc_drive_o,
   output logic external_clock_select_o,
   output logic high_osc_out_pin_o,
   output logic standby_pin_hold_o,
   output logic protect_on_o,
   output logic gear_clock_en_o,
   output logic sys_clock_en_o,
   output logic protect_violation_irq_o
);
   // =========================================
   // register state
   logic high_osc_enable;
   logic low_osc_enable;
   logic clock_source_select;
   logic [2:0] gear_select;
   logic [2:0] gear_act;
   logic [1:0] warmup_select;
   logic pin_state;
   logic high_osc_drive;
   logic low_osc_drive;
   logic external_clock_select;
   logic protect;
   scg_key_t key_st;
   logic warm_busy;
   logic [16:0] warm_cnt;
   logic hf_q;
   logic lf_q;
   logic [3:0] div_cnt;
   logic half;

   // =========================================
   // bus decode
   logic [13:0] idx;
   logic mapped;
   logic acc;
   logic wr;
   logic guarded;
   logic blocked;
   logic wr_ok;
   logic [7:0] wb;
   logic hf_edge;
   logic lf_edge;
   logic tgt_edge;
   logic gear_tick;
   logic src_tick;
   logic [16:0] warm_lim;

   assign idx = paddr_i[15:2];
   assign mapped = (idx >= IDX_OSC) && (idx <= IDX_KB);
   assign acc = psel_i && penable_i && pready_o;
   assign wr = acc && pwrite_i && mapped;
   assign wb = pwdata_i[7:0];
   // key registers stay writable so protection can be lifted
   assign guarded = (idx == IDX_OSC) || (idx == IDX_SRC) || (idx == IDX_WCF) || (idx == IDX_STA);
   assign blocked = wr && guarded && protect;
   assign wr_ok = wr && !blocked;

   // gear mask: code n divides by 2^n, codes above 100 act as 100
   function automatic logic [3:0] gear_mask(input logic [2:0] g);
      logic [3:0] m;
      m = 4'hf;
      if (g < 3'h4) begin
         m = 4'((5'h1 << g) - 5'h1);
      end
      return m;
   endfunction

   // warm-up length for the select code; 00 ends at once
   function automatic logic [16:0] warm_len(input logic [1:0] s);
      logic [16:0] n;
      case (s)
         2'h1: n = 17'(WARM_S);
         2'h2: n = 17'(WARM_M);
         2'h3: n = 17'(WARM_L);
         default: n = 17'h0;
      endcase
      return n;
   endfunction

   assign hf_edge = high_freq_clock_i && !hf_q && high_osc_enable;
   assign lf_edge = low_freq_clock_i && !lf_q && low_osc_enable;
   assign tgt_edge = clock_source_select ? hf_edge : lf_edge;
   assign gear_tick = hf_edge && ((div_cnt & gear_mask(gear_act)) == gear_mask(gear_act));
   assign src_tick = clock_source_select ? lf_edge : gear_tick;
   assign warm_lim = warm_len(warmup_select);

   // =========================================
   // apb slave: one wait state, answer from flops
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0;
      end else if (psel_i && penable_i && !pready_o) begin
         pready_o <= 1'b1;
         pslverr_o <= !mapped;
         prdata_o <= 32'h0;
         if (!pwrite_i) begin
            case (idx)
               IDX_OSC: begin
                  prdata_o[B_HEN] <= high_osc_enable;
                  prdata_o[B_LEN] <= low_osc_enable;
                  prdata_o[B_WUP] <= warm_busy;
               end
               IDX_SRC: begin
                  prdata_o[B_SRC] <= clock_source_select;
                  prdata_o[2:0] <= gear_select;
               end
               IDX_WCF: begin
                  prdata_o[B_WSEL+1:B_WSEL] <= warmup_select;
                  prdata_o[B_PIN] <= pin_state;
               end
               IDX_STA: begin
                  prdata_o[B_PROT] <= protect;
                  prdata_o[B_EXT] <= external_clock_select;
                  prdata_o[B_HDRV] <= high_osc_drive;
                  prdata_o[B_LDRV] <= low_osc_drive;
               end
               default: prdata_o <= 32'h0;
            endcase
         end
      end else begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   // =========================================
   // control registers, guarded by protection
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         high_osc_enable <= 1'b1;
         low_osc_enable <= 1'b1;
         clock_source_select <= 1'b0;
         gear_select <= RST_GEAR;
         warmup_select <= RST_WSEL;
         pin_state <= 1'b0;
         high_osc_drive <= 1'b1;
         low_osc_drive <= 1'b1;
         external_clock_select <= 1'b0;
      end else if (wr_ok) begin
         case (idx)
            IDX_OSC: begin
               high_osc_enable <= wb[B_HEN];
               low_osc_enable <= wb[B_LEN];
            end
            IDX_SRC: begin
               clock_source_select <= wb[B_SRC];
               gear_select <= wb[2:0];
            end
            IDX_WCF: begin
               warmup_select <= wb[B_WSEL+1:B_WSEL];
               pin_state <= wb[B_PIN];
            end
            IDX_STA: begin
               external_clock_select <= wb[B_EXT];
               high_osc_drive <= wb[B_HDRV];
               low_osc_drive <= wb[B_LDRV];
            end
            default: ;
         endcase
      end
   end

   // =========================================
   // double key; any other write sends detection to idle, or to KS_1A if it is KEY_P to IDX_KA outside KS_1B
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         key_st <= KS_IDLE;
         protect <= 1'b0;
      end else if (wr) begin
         key_st <= KS_IDLE;
         case (key_st)
            KS_IDLE: if (idx == IDX_KA && wb == KEY_P) key_st <= KS_1A;
            KS_1A: if (idx == IDX_KB && wb == KEY_Q) key_st <= KS_1B;
            KS_1B: if (idx == IDX_KA && wb == KEY_Q) key_st <= KS_2A;
            KS_2A: if (idx == IDX_KB && wb == KEY_P) protect <= !protect;
            default: key_st <= KS_IDLE;
         endcase
         if (key_st != KS_1B && idx == IDX_KA && wb == KEY_P) key_st <= KS_1A;
      end
   end

   // =========================================
   // violation request: one pulse per refused write
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         protect_violation_irq_o <= 1'b0;
      end else begin
         protect_violation_irq_o <= blocked || (ext_protected_write_i && protect);
      end
   end

   // =========================================
   // warm-up timer; a zero written to the start bit does nothing
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         warm_busy <= 1'b0;
         warm_cnt <= 17'h0;
      end else if (wr_ok && idx == IDX_OSC && wb[B_WUP]) begin
         warm_cnt <= 17'h0;
         warm_busy <= (warm_lim != 17'h0);
      end else if (warm_busy && tgt_edge) begin
         warm_cnt <= warm_cnt + 17'h1;
         if (warm_cnt + 17'h1 >= warm_lim) warm_busy <= 1'b0;
      end
   end

   // =========================================
   // oscillator edge sampling and gear divider
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hf_q <= 1'b0;
         lf_q <= 1'b0;
      end else begin
         hf_q <= high_freq_clock_i;
         lf_q <= low_freq_clock_i;
      end
   end

   // new gear waits for the divider to wrap, so it lands late
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_cnt <= 4'h0;
         gear_act <= RST_GEAR;
      end else if (hf_edge) begin
         div_cnt <= div_cnt + 4'h1;
         if (div_cnt == 4'hf) gear_act <= gear_select;
      end
   end

   // system clock is the chosen source halved
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         half <= 1'b0;
         gear_clock_en_o <= 1'b0;
         sys_clock_en_o <= 1'b0;
      end else begin
         gear_clock_en_o <= gear_tick;
         sys_clock_en_o <= src_tick && half;
         if (src_tick) half <= !half;
      end
   end

   // =========================================
   // pin-side outputs
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         high_osc_run_o <= 1'b1;
         low_osc_run_o <= 1'b1;
         high_osc_drive_o <= 1'b1;
         low_osc_drive_o <= 1'b1;
         external_clock_select_o <= 1'b0;
         high_osc_out_pin_o <= 1'b0;
         standby_pin_hold_o <= 1'b0;
         protect_on_o <= 1'b0;
      end else begin
         high_osc_run_o <= high_osc_enable && !external_clock_select;
         low_osc_run_o <= low_osc_enable;
         high_osc_drive_o <= high_osc_drive;
         low_osc_drive_o <= low_osc_drive;
         external_clock_select_o <= external_clock_select;
         high_osc_out_pin_o <= external_clock_select;
         standby_pin_hold_o <= pin_state;
         protect_on_o <= protect;
      end
   end

   // =========================================
   // checks
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   property p_key_toggle;
      wr && key_st == KS_2A && idx == IDX_KB && wb == KEY_P |=> protect != $past(protect);
   endproperty
   a_key_toggle: assert property (p_key_toggle) else $error("key did not toggle");

   property p_no_toggle;
      wr && key_st != KS_2A |=> protect == $past(protect);
   endproperty
   a_no_toggle: assert property (p_no_toggle) else $error("stray toggle");

   property p_blocked_keep;
      blocked && idx == IDX_SRC |=> $stable(clock_source_select) && $stable(gear_select);
   endproperty
   a_blocked_keep: assert property (p_blocked_keep) else $error("blocked write landed");

   property p_irq;
      blocked |=> protect_violation_irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("no violation pulse");

   property p_warm_start;
      wr_ok && idx == IDX_OSC && wb[B_WUP] && warmup_select != 2'h0
         |=> warm_busy && warm_cnt == 17'h0;
   endproperty
   a_warm_start: assert property (p_warm_start) else $error("warm-up not started");

   property p_warm_zero;
      wr_ok && idx == IDX_OSC && !wb[B_WUP] && !warm_busy |=> !warm_busy;
   endproperty
   a_warm_zero: assert property (p_warm_zero) else $error("zero started warm-up");

   property p_warm_end;
      // a restart in the same cycle as the last edge keeps the timer busy
      warm_busy && tgt_edge && warm_cnt + 17'h1 == warm_lim
         && !(wr_ok && idx == IDX_OSC && wb[B_WUP]) |=> !warm_busy;
   endproperty
   a_warm_end: assert property (p_warm_end) else $error("warm-up overran");

   property p_ext_pin;
      external_clock_select |=> high_osc_out_pin_o && !high_osc_run_o;
   endproperty
   a_ext_pin: assert property (p_ext_pin) else $error("external mode pins wrong");
endmodule

// [scg_osc_model.sv]
// Purpose: stand-in for the crystal pair on the far side of the clock block
// Assumes: both oscillators run well below mclk_i / 2
// Notes: a stopped oscillator holds its line low instead of freezing mid-level
module scg_osc_model (
   input wire logic mclk_i,
   input wire logic high_run_i,
   input wire logic low_run_i,
   output logic high_freq_clock_o,
   output logic low_freq_clock_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div = 3'h0;
   logic h = 1'b0;
   logic l = 1'b0;
   // =========================================
   // high osc period 4 cycles, low osc period 16 cycles
   always @(posedge mclk_i) begin
      div <= div + 3'h1;
      if (!high_run_i) h <= 1'b0;
      else if (div[0]) h <= ~h;
      if (!low_run_i) l <= 1'b0;
      else if (div == 3'h7) l <= ~l;
   end
   assign high_freq_clock_o = h;
   assign low_freq_clock_o = l;
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the clock gear and protect block
// Assumes: short warm-up counts 4/8/16 oscillator edges
// Notes: register model with key sequencer predicts every read and request
module testbench import scg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, xpw = 1'b0, prot = 1'b0, b;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, hclk, lclk, hrun, lrun, hdrv, ldrv, ext, opin, hold, pon;
   logic gen, sen, irq;
   int fails = 0, checked = 0, cyc = 0, irqs = 0, xirq = 0, seed = 2829, st = 0;
   int t0, n, k, nn;
   logic [7:0] mdl [6] = '{8'hc0, 8'h04, 8'h20, 8'h03, 8'h00, 8'h00};
   localparam logic [7:0] MSK [6] = '{8'hc4, 8'h0f, 8'h31, 8'h87, 8'hff, 8'hff};
   localparam logic [7:0] WM [4] = '{8'hc0, 8'h0f, 8'h31, 8'h07};
   scg_clock_ctrl #(.WARM_S(4), .WARM_M(8), .WARM_L(16)) u_scg_clock_ctrl (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .high_freq_clock_i(hclk),
      .low_freq_clock_i(lclk), .ext_protected_write_i(xpw), .high_osc_run_o(hrun),
      .low_osc_run_o(lrun), .high_osc_drive_o(hdrv), .low_osc_drive_o(ldrv),
      .external_clock_select_o(ext), .high_osc_out_pin_o(opin),
      .standby_pin_hold_o(hold), .protect_on_o(pon), .gear_clock_en_o(gen),
      .sys_clock_en_o(sen), .protect_violation_irq_o(irq));
   scg_osc_model u_scg_osc_model (.mclk_i(mclk_i), .high_run_i(hrun), .low_run_i(lrun),
      .high_freq_clock_o(hclk), .low_freq_clock_o(lclk));
   // =========================================
   // clock, request counter and hang guard
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cyc++;
      if (irq === 1'b1) irqs++;
      if (cyc == 30000) begin
         fails++;
         close_out;
      end
   end
   // =========================================
   // shared tasks
   task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; the model updates only once pready is sampled
   task automatic apb(input bit w, input logic [13:0] idx, input logic [7:0] d);
      int i;
      i = int'(idx) - int'(IDX_OSC);
      @(posedge mclk_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge mclk_i);
      pen <= 1'b1;
      // no assumed latency: only the hang guard ends this wait
      do begin
         @(posedge mclk_i);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (w && i != 4 && i != 5) st = 0;
      if (w && i >= 0 && i < 4 && prot) xirq++;
      else if (w && i >= 0 && i < 4) mdl[i] = d & WM[i];
      else if (w && i == 4) st = (d == KEY_P && st != 2) ? 1 : (d == KEY_Q && st == 2) ? 3 : 0;
      else if (w && i == 5) begin
         if (d == KEY_Q && st == 1) st = 2;
         else begin
            if (d == KEY_P && st == 3) prot = ~prot;
            st = 0;
         end
      end
   endtask
   task automatic rg(input int i);
      logic [7:0] e;
      e = (i == 3) ? {prot, mdl[3][6:0]} : mdl[i];
      apb(1'b0, IDX_OSC + 14'(i), 8'h00);
      ck("register", rd, {24'h0, e & MSK[i]});
      ck("slverr", err, 1'b0);
   endtask
   // pin outputs trail a register write by two edges
   task automatic outs;
      repeat (2) @(posedge mclk_i);
      ck("hrun", hrun, mdl[0][7] & ~mdl[3][2]);
      ck("lrun", lrun, mdl[0][6]);
      ck("hdrv", hdrv, mdl[3][1]);
      ck("ldrv", ldrv, mdl[3][0]);
      ck("ext", {ext, opin}, {2{mdl[3][2]}});
      ck("hold", hold, mdl[2][0]);
      ck("prot", pon, prot);
   endtask
   task automatic gap(input bit s);
      k = 0;
      n = 0;
      do begin
         @(posedge mclk_i);
         k++;
      end while ((s ? sen : gen) !== 1'b1 && k < 300);
      do begin
         @(posedge mclk_i);
         n++;
      end while ((s ? sen : gen) !== 1'b1 && n < 300);
   endtask
   task automatic chkirq;
      repeat (3) @(posedge mclk_i);
      ck("irq", irqs, xirq);
   endtask
   task automatic keys;
      apb(1'b1, IDX_KA, KEY_P);
      apb(1'b1, IDX_KB, KEY_Q);
      apb(1'b1, IDX_KA, KEY_Q);
      apb(1'b1, IDX_KB, KEY_P);
   endtask
   task close_out;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // =========================================
   // main sequence
   initial begin
      repeat (4) @(posedge mclk_i);
      resetn_i <= 1'b1;
      outs;
      for (int i = 0; i < 6; i++) rg(i);
      apb(1'b0, 14'h10e6, 8'h00);
      ck("unmapped", err, 1'b1);
      repeat (4) begin
         apb(1'b1, IDX_STA, 8'($random(seed)));
         rg(3);
         outs;
      end
      apb(1'b1, IDX_STA, 8'h03);
      // code 00 never starts the timer
      apb(1'b1, IDX_WCF, 8'h00);
      apb(1'b1, IDX_OSC, 8'hc4);
      rg(0);
      for (int c = 1; c < 4; c++) begin
         nn = (c == 3) ? 16 : 4 * c;
         apb(1'b1, IDX_WCF, {2'b00, c[1:0], 4'h0});
         t0 = cyc;
         apb(1'b1, IDX_OSC, 8'hc4);
         apb(1'b1, IDX_OSC, 8'hc0);
         t0 = t0 + 0;
         n = 0;
         do begin
            apb(1'b0, IDX_OSC, 8'h00);
            if (n == 0) b = rd[2];
            n++;
         end while (rd[2] === 1'b1 && n < 200);
         ck("busy", b, 1'b1);
         ck("warm", 32'(cyc - t0 > 16 * (nn - 1) && cyc - t0 < 16 * nn + 40), 1);
      end
      // move to the low source, then stop the high oscillator
      apb(1'b1, IDX_SRC, 8'h0c);
      apb(1'b1, IDX_OSC, 8'h40);
      outs;
      gap(1'b1);
      gap(1'b1);
      ck("sys low", n, 32);
      apb(1'b1, IDX_OSC, 8'hc0);
      for (int g = 0; g < 6; g++) begin
         apb(1'b1, IDX_SRC, 8'(g));
         apb(1'b1, IDX_KA, 8'h00);
         // new gear lands only when the divider wraps, up to 64 cycles on
         repeat (70) @(posedge mclk_i);
         gap(1'b0);
         gap(1'b0);
         ck("gear", n, 4 << (g > 4 ? 4 : g));
         gap(1'b1);
         ck("sys high", n, 8 << (g > 4 ? 4 : g));
      end
      keys;
      rg(3);
      outs;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, IDX_OSC + 14'(i), 8'h00);
         chkirq;
         rg(i);
      end
      @(posedge mclk_i) xpw <= 1'b1;
      @(posedge mclk_i) xpw <= 1'b0;
      xirq++;
      chkirq;
      // a write between the two key pairs restarts detection
      apb(1'b1, IDX_KA, KEY_P);
      apb(1'b1, IDX_KB, KEY_Q);
      apb(1'b1, IDX_WCF, 8'h10);
      apb(1'b1, IDX_KA, KEY_Q);
      apb(1'b1, IDX_KB, KEY_P);
      rg(3);
      keys;
      rg(3);
      apb(1'b1, IDX_SRC, 8'h01);
      rg(1);
      chkirq;
      outs;
      close_out;
   end
endmodule
